// ==== design/clk_ctrl_pkg.sv ====
package clk_ctrl_pkg;

  // Clock sources, in the order of the source level vector.
  localparam int N_SRC = 7;
  typedef enum logic [2:0] {
    SRC_RING    = 3'h0,
    SRC_XTAL    = 3'h1,
    SRC_PLL_SYS = 3'h2,
    SRC_PLL_USB = 3'h3,
    SRC_GPIN0   = 3'h4,
    SRC_GPIN1   = 3'h5,
    SRC_SYS     = 3'h6
  } clk_src_t;

  // Generator indices.
  localparam int N_GEN   = 7;
  localparam int GEN_REF = 0;
  localparam int GEN_SYS = 1;
  localparam int GEN_RTC = 2;
  localparam int GEN_GP0 = 3;
  localparam int N_GPOUT = 4;

  // Permitted sources per generator, one bit per clk_src_t code.
  localparam logic [N_SRC-1:0] MASK_REF = 7'h33;
  localparam logic [N_SRC-1:0] MASK_SYS = 7'h3F;
  localparam logic [N_SRC-1:0] MASK_RTC = 7'h3B;
  localparam logic [N_SRC-1:0] MASK_GP  = 7'h7F;

  // Asynchronous input pins, in the order of the synchroniser vector.
  localparam int N_PIN     = 7;
  localparam int PIN_XIN   = 0;
  localparam int PIN_GPIN0 = 1;
  localparam int PIN_GPIN1 = 2;
  localparam int PIN_PLLS  = 3;
  localparam int PIN_PLLU  = 4;
  localparam int PIN_ALARM = 5;
  localparam int PIN_WAKE  = 6;

  // Widths and reset values.
  localparam int              DIV_W        = 8;
  localparam int              FC_W         = 16;
  localparam logic [DIV_W-1:0] RING_DIV_RST = 8'h01;

  // Timing, in nanoseconds, and the cycle counts derived from them.
  localparam int CLK_PERIOD_NS    = 100;
  localparam int FC_WINDOW_NS     = 100000;
  localparam int RESUS_TIMEOUT_NS = 10000;
  localparam int WAKE_SETTLE_NS   = 1000;
  localparam int FC_WINDOW_CYC    = FC_WINDOW_NS / CLK_PERIOD_NS;
  localparam int RESUS_CYC        = RESUS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int WAKE_CYC         = WAKE_SETTLE_NS / CLK_PERIOD_NS;

  // Deep-stop sequencer, Gray coded along run, halt, deep, wake.
  typedef enum logic [1:0] {
    DS_RUN  = 2'b00,
    DS_HALT = 2'b01,
    DS_DEEP = 2'b11,
    DS_WAKE = 2'b10
  } deep_state_t;

  function automatic logic [N_SRC-1:0] gen_mask(input int g);
    if (g == GEN_REF) return MASK_REF;
    else if (g == GEN_SYS) return MASK_SYS;
    else if (g == GEN_RTC) return MASK_RTC;
    else return MASK_GP;
  endfunction

endpackage

// ==== design/clk_gen_unit.sv ====
`timescale 1ns/1ps
module clk_gen_unit #(
  parameter logic [clk_ctrl_pkg::N_SRC-1:0] SRC_MASK = 7'h7F,
  parameter int                             DW       = 8
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // Source levels and their rising-edge strobes
  input  wire logic [clk_ctrl_pkg::N_SRC-1:0] src_lvl,
  input  wire logic [clk_ctrl_pkg::N_SRC-1:0] src_rise,
  // Configuration
  input  clk_ctrl_pkg::clk_src_t              sel_req,
  input  wire logic [DW-1:0]                  div_req,
  input  wire logic                           enable,
  input  wire logic                           sleep_state,
  input  wire logic                           sleep_gate_en,
  input  wire logic                           force_en,
  input  clk_ctrl_pkg::clk_src_t              force_sel,
  // Generated clock and its current selection
  output logic                                gen_lvl,
  output clk_ctrl_pkg::clk_src_t              cur_sel
);
  import clk_ctrl_pkg::*;

  if (DW < 1 || DW > 16) begin : g_bad_dw
    $error("clk_gen_unit: DW must be 1 to 16");
  end

  clk_src_t      sel_q;
  logic [DW-1:0] div_q;
  logic [DW-1:0] cnt_q;
  logic          run_q;
  logic          armed_q;
  logic          lvl_q;

  wire clk_src_t eff_sel  = force_en ? force_sel : sel_req;
  wire logic     sel_ok   = SRC_MASK[eff_sel];
  wire logic     run_want = enable & ~(sleep_state & sleep_gate_en);
  wire logic     change   = (sel_ok && eff_sel != sel_q) || run_want != run_q
                            || div_req != div_q;
  // Changes land only in the low phase so no high pulse is cut short; a forced
  // recovery may not wait, since its old source may be stuck high.
  wire logic     apply    = change && (!lvl_q || force_en);
  wire logic     s_rise   = src_rise[sel_q];
  wire logic     last     = cnt_q == div_q - DW'(1);
  wire logic     bypass   = div_q == '0;
  wire logic     lvl_byp  = run_q & (armed_q | s_rise) & src_lvl[sel_q];
  wire logic     lvl_div  = (run_q && s_rise && last) ? ~lvl_q : lvl_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= SRC_RING;
      div_q <= '0;
      run_q <= 1'b0;
    end else if (apply) begin
      sel_q <= sel_ok ? eff_sel : sel_q;
      div_q <= div_req;
      run_q <= run_want;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || apply) begin
      cnt_q   <= '0;
      armed_q <= 1'b0;
      lvl_q   <= 1'b0;
    end else begin
      armed_q <= armed_q | s_rise;
      lvl_q   <= bypass ? lvl_byp : (run_q & lvl_div);
      if (run_q && s_rise && !bypass) begin
        cnt_q <= last ? '0 : cnt_q + DW'(1);
      end
    end
  end

  assign gen_lvl = lvl_q;
  assign cur_sel = sel_q;

endmodule // clk_gen_unit

// ==== design/chip_clock_source_control.sv ====
`timescale 1ns/1ps
// Contract
// - Generator selects source, divides, gates output.
// - Sleep state gates generator clocks automatically.
// - Ref, sys and RTC generators have their own source lists; the four GPIO generators share one.
// - Recovery restarts stopped system clock from ring.
// - Frequency counter measures any selected clock.
// - Deep stop halts all on-chip sources.
// - External clocks keep running through deep stop.
// - Alarm or GPIO event wakes deep stop.
// - Four generated clocks routable to GPIO pins.
// - Crystal is reference for both PLLs.
// - Ring oscillator starts alone at reset.
// - Sleep does not affect ring oscillator.
// - Ring halts in deep stop, keeps configuration.
// - Ring oscillator selectable by GPIO clock generators.
// - Crystal halts in deep stop, keeps configuration.
module chip_clock_source_control #(
  parameter int RESUS_CYCLES = clk_ctrl_pkg::RESUS_CYC,
  parameter int FC_CYCLES    = clk_ctrl_pkg::FC_WINDOW_CYC,
  parameter int WAKE_CYCLES  = clk_ctrl_pkg::WAKE_CYC
) (
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  // Asynchronous clock and event pins
  input  wire logic                                  xin_pin,
  input  wire logic                                  gpin0_pin,
  input  wire logic                                  gpin1_pin,
  input  wire logic                                  pll_sys_in,
  input  wire logic                                  pll_usb_in,
  input  wire logic                                  rtc_alarm_in,
  input  wire logic                                  gpio_wake_in,
  // Oscillator control
  input  wire logic                                  ring_stop_req,
  input  wire logic [clk_ctrl_pkg::DIV_W-1:0]        ring_div,
  input  wire logic                                  crystal_enable,
  output logic                                       ring_run,
  output logic                                       crystal_run,
  output logic                                       pll_ref_clk,
  // Generator configuration
  input  clk_ctrl_pkg::clk_src_t                     gen_sel [clk_ctrl_pkg::N_GEN],
  input  wire logic [clk_ctrl_pkg::DIV_W-1:0]        gen_div [clk_ctrl_pkg::N_GEN],
  input  wire logic [clk_ctrl_pkg::N_GEN-1:0]        gen_enable,
  input  wire logic [clk_ctrl_pkg::N_GEN-1:0]        gen_sleep_gate,
  input  wire logic                                  sleep_state,
  // Generated clocks
  output logic [clk_ctrl_pkg::N_GEN-1:0]             gen_clk,
  input  wire logic [clk_ctrl_pkg::N_GPOUT-1:0]      gpio_route_en,
  output logic [clk_ctrl_pkg::N_GPOUT-1:0]           gpio_clk_out,
  output logic [clk_ctrl_pkg::N_GPOUT-1:0]           gpio_clk_oe,
  // Deep stop
  input  wire logic                                  deep_stop_req,
  output logic                                       deep_stop_state,
  // Clock recovery
  input  wire logic                                  resus_clear,
  output logic                                       resus_active,
  // Frequency counter
  input  clk_ctrl_pkg::clk_src_t                     fc_sel,
  input  wire logic                                  fc_start,
  output logic                                       fc_busy,
  output logic                                       fc_done,
  output logic [clk_ctrl_pkg::FC_W-1:0]              fc_count
);
  import clk_ctrl_pkg::*;

  if (RESUS_CYCLES < 2 || FC_CYCLES < 1 || WAKE_CYCLES < 1) begin : g_bad_param
    $error("chip_clock_source_control: cycle counts out of range");
  end

  localparam int RC_W = $clog2(RESUS_CYCLES + 1);
  localparam int FW_W = $clog2(FC_CYCLES + 1);
  localparam int WK_W = $clog2(WAKE_CYCLES + 1);

  // ---------------------------------------------------------------------------
  // Pin synchronisers: the first stage feeds only the second.
  // ---------------------------------------------------------------------------
  logic [N_PIN-1:0] pin_s1_q;
  logic [N_PIN-1:0] pin_s2_q;
  wire  logic [N_PIN-1:0] pin_raw = {gpio_wake_in, rtc_alarm_in, pll_usb_in, pll_sys_in,
                                     gpin1_pin, gpin0_pin, xin_pin};

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Deep-stop sequencer.
  // ---------------------------------------------------------------------------
  deep_state_t     ds_q;
  deep_state_t     ds_d;
  logic [WK_W-1:0] wake_cnt_q;

  wire logic wake_evt = pin_s2_q[PIN_ALARM] | pin_s2_q[PIN_WAKE];
  wire logic halted   = ds_q == DS_HALT || ds_q == DS_DEEP;
  wire logic wake_end = wake_cnt_q == WK_W'(WAKE_CYCLES - 1);

  always_comb begin
    ds_d = ds_q;
    unique case (ds_q)
      DS_RUN:  if (deep_stop_req) ds_d = DS_HALT;
      DS_HALT: ds_d = DS_DEEP;
      DS_DEEP: if (wake_evt) ds_d = DS_WAKE;
      DS_WAKE: if (wake_end) ds_d = DS_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ds_q       <= DS_RUN;
      wake_cnt_q <= '0;
    end else begin
      ds_q       <= ds_d;
      wake_cnt_q <= (ds_q == DS_WAKE) ? wake_cnt_q + WK_W'(1) : '0;
    end
  end

  assign deep_stop_state = ds_q != DS_RUN;

  // ---------------------------------------------------------------------------
  // Ring oscillator model: a divider of clk whose configuration is held
  // through deep stop, so it resumes at the same rate on wake.
  // ---------------------------------------------------------------------------
  logic [DIV_W-1:0] ring_div_q;
  logic [DIV_W-1:0] ring_cnt_q;
  logic             ring_lvl_q;
  logic             ring_run_q;
  logic             xtal_run_q;
  logic             resus_q;

  // Sleep is deliberately absent here: the ring keeps running in sleep.
  wire logic ring_on = (~ring_stop_req | resus_q) & ~halted;
  wire logic xtal_on = crystal_enable & ~halted;
  wire logic ring_wrap = ring_cnt_q >= ring_div_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ring_div_q <= RING_DIV_RST;
    end else if (ds_q == DS_RUN) begin
      ring_div_q <= ring_div;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !ring_run_q) begin
      ring_cnt_q <= '0;
      ring_lvl_q <= 1'b0;
    end else if (ring_wrap) begin
      ring_cnt_q <= '0;
      ring_lvl_q <= ~ring_lvl_q;
    end else begin
      ring_cnt_q <= ring_cnt_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ring_run_q <= 1'b1;
      xtal_run_q <= 1'b0;
    end else begin
      ring_run_q <= ring_on;
      xtal_run_q <= xtal_on;
    end
  end

  assign ring_run    = ring_run_q;
  assign crystal_run = xtal_run_q;

  // ---------------------------------------------------------------------------
  // Source levels and edges. External pins other than XIN are never gated by deep stop.
  // ---------------------------------------------------------------------------
  logic [N_SRC-1:0] src_lvl;
  logic [N_SRC-1:0] src_prev_q;
  logic [N_SRC-1:0] src_rise;
  logic [N_GEN-1:0] gen_lvl;
  logic             pll_ref_q;

  always_comb begin
    src_lvl              = '0;
    src_lvl[SRC_RING]    = ring_lvl_q;
    src_lvl[SRC_XTAL]    = xtal_run_q & pin_s2_q[PIN_XIN];
    src_lvl[SRC_PLL_SYS] = pin_s2_q[PIN_PLLS];
    src_lvl[SRC_PLL_USB] = pin_s2_q[PIN_PLLU];
    src_lvl[SRC_GPIN0]   = pin_s2_q[PIN_GPIN0];
    src_lvl[SRC_GPIN1]   = pin_s2_q[PIN_GPIN1];
    src_lvl[SRC_SYS]     = gen_lvl[GEN_SYS];
  end

  assign src_rise = src_lvl & ~src_prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      src_prev_q <= '0;
      pll_ref_q  <= 1'b0;
    end else begin
      src_prev_q <= src_lvl;
      pll_ref_q  <= src_lvl[SRC_XTAL];
    end
  end

  // Both PLLs share this reference; they stall with it in deep stop.
  assign pll_ref_clk = pll_ref_q;

  // ---------------------------------------------------------------------------
  // Clock generators. Only the system generator can be forced by recovery.
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < N_GEN; g++) begin : g_gen
    clk_gen_unit #(
      .SRC_MASK (gen_mask(g)),
      .DW       (DIV_W)
    ) u_gen (
      .clk           (clk),
      .rst           (rst),
      .src_lvl       (src_lvl),
      .src_rise      (src_rise),
      .sel_req       (gen_sel[g]),
      .div_req       (gen_div[g]),
      .enable        (gen_enable[g]),
      .sleep_state   (sleep_state),
      .sleep_gate_en (gen_sleep_gate[g]),
      .force_en      ((g == GEN_SYS) ? resus_q : 1'b0),
      .force_sel     (SRC_RING),
      .gen_lvl       (gen_lvl[g]),
      .cur_sel       ()
    );
  end

  assign gen_clk = gen_lvl;

  // ---------------------------------------------------------------------------
  // GPIO clock outputs.
  // ---------------------------------------------------------------------------
  logic [N_GPOUT-1:0] gp_oe_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      gp_oe_q <= '0;
    end else begin
      gp_oe_q <= gpio_route_en;
    end
  end

  assign gpio_clk_out = gen_lvl[GEN_GP0 +: N_GPOUT];
  assign gpio_clk_oe  = gp_oe_q;

  // ---------------------------------------------------------------------------
  // Clock recovery: a system clock that is expected to run but shows no
  // rising edge for the timeout is forced onto the ring oscillator. The flag
  // stays until cleared; a new detection in the clear cycle wins.
  // ---------------------------------------------------------------------------
  logic [RC_W-1:0] resus_cnt_q;

  wire logic sys_rise   = gen_lvl[GEN_SYS] & ~src_prev_q[SRC_SYS];
  wire logic sys_expect = gen_enable[GEN_SYS] & ~(sleep_state & gen_sleep_gate[GEN_SYS])
                          & (ds_q == DS_RUN);
  wire logic resus_hit  = resus_cnt_q == RC_W'(RESUS_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (rst || !sys_expect || sys_rise || resus_q) begin
      resus_cnt_q <= '0;
    end else if (!resus_hit) begin
      resus_cnt_q <= resus_cnt_q + RC_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resus_q <= 1'b0;
    end else if (resus_hit && sys_expect && !sys_rise) begin
      resus_q <= 1'b1;
    end else if (resus_clear) begin
      resus_q <= 1'b0;
    end
  end

  assign resus_active = resus_q;

  // ---------------------------------------------------------------------------
  // Frequency counter: counts rising edges of the chosen source over a fixed
  // window. Edges above half the clk rate alias, which limits its range.
  // ---------------------------------------------------------------------------
  logic [FW_W-1:0] fc_win_q;
  logic [FC_W-1:0] fc_acc_q;
  logic [FC_W-1:0] fc_res_q;
  logic            fc_busy_q;
  logic            fc_done_q;
  clk_src_t        fc_sel_q;

  wire logic fc_edge = src_rise[fc_sel_q];
  wire logic fc_last = fc_win_q == FW_W'(FC_CYCLES - 1);
  wire logic fc_sat  = &fc_acc_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      fc_busy_q <= 1'b0;
      fc_done_q <= 1'b0;
      fc_sel_q  <= SRC_RING;
      fc_win_q  <= '0;
      fc_acc_q  <= '0;
      fc_res_q  <= '0;
    end else begin
      fc_done_q <= fc_busy_q & fc_last;
      if (!fc_busy_q && fc_start) begin
        fc_busy_q <= 1'b1;
        fc_sel_q  <= fc_sel;
        fc_win_q  <= '0;
        fc_acc_q  <= '0;
      end else if (fc_busy_q) begin
        fc_win_q  <= fc_win_q + FW_W'(1);
        fc_acc_q  <= (fc_edge && !fc_sat) ? fc_acc_q + FC_W'(1) : fc_acc_q;
        if (fc_last) begin
          fc_busy_q <= 1'b0;
          fc_res_q  <= (fc_edge && !fc_sat) ? fc_acc_q + FC_W'(1) : fc_acc_q;
        end
      end
    end
  end

  assign fc_busy  = fc_busy_q;
  assign fc_done  = fc_done_q;
  assign fc_count = fc_res_q;

endmodule // chip_clock_source_control

// ==== verif/chip_clock_source_control_asserts.sv ====
`timescale 1ns/1ps
module chip_clock_source_control_asserts #(
  parameter int FC_CYCLES = 1000
) (
  // Clock and reset
  input wire logic                             clk,
  input wire logic                             rst,
  // Oscillators and wake pins
  input wire logic                             ring_run,
  input wire logic                             crystal_run,
  input wire logic                             crystal_enable,
  input wire logic                             pll_ref_clk,
  input wire logic                             rtc_alarm_in,
  input wire logic                             gpio_wake_in,
  // Generators
  input wire logic [clk_ctrl_pkg::N_GEN-1:0]   gen_clk,
  input wire logic [clk_ctrl_pkg::N_GEN-1:0]   gen_enable,
  input wire logic [clk_ctrl_pkg::N_GEN-1:0]   gen_sleep_gate,
  input wire logic                             sleep_state,
  input wire logic [clk_ctrl_pkg::N_GPOUT-1:0] gpio_route_en,
  input wire logic [clk_ctrl_pkg::N_GPOUT-1:0] gpio_clk_oe,
  // Deep stop, recovery and counter
  input wire logic                             deep_stop_req,
  input wire logic                             deep_stop_state,
  input wire logic                             resus_active,
  input wire logic                             fc_start,
  input wire logic                             fc_busy,
  input wire logic                             fc_done
);
  import clk_ctrl_pkg::*;
  localparam int WAKE_MAX = 40;
  logic [15:0] busy_len_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    busy_len_q <= (rst || !fc_busy) ? 16'h0000 : busy_len_q + 16'h0001;
  end
  sequence s_halted;
    deep_stop_state ##1 (!ring_run && !crystal_run);
  endsequence
  // Four cycles, because a wake pulse still inside the synchroniser is invisible here.
  sequence s_deep_stop_state;
    deep_stop_state && !ring_run && !rtc_alarm_in && !gpio_wake_in;
  endsequence
  AST_RESET_STATE: assert property ($fell(rst) |-> ring_run && !crystal_run && gen_clk == '0
    && !deep_stop_state && !resus_active) else $error("reset state wrong");
  AST_ENABLE_GATE: assert property (((gen_clk & ~$past(gen_clk) & ~gen_enable
    & ~$past(gen_enable)) == '0)) else $error("disabled generator rose");
  AST_SLEEP_GATE: assert property (sleep_state && $past(sleep_state) |->
    (gen_clk & ~$past(gen_clk) & gen_sleep_gate & $past(gen_sleep_gate)) == '0)
    else $error("sleep gated generator rose");
  AST_ROUTE_OE: assert property (!$past(rst) |-> gpio_clk_oe == $past(gpio_route_en))
    else $error("gpio enable wrong");
  AST_DEEP_ENTRY: assert property (!deep_stop_state && deep_stop_req |=> s_halted)
    else $error("deep stop entry wrong");
  AST_DEEP_HOLD: assert property (s_deep_stop_state [*4] |=> !ring_run)
    else $error("ring ran in deep stop");
  AST_WAKE_EXIT: assert property ($rose(ring_run) && deep_stop_state |->
    ##[1:WAKE_MAX] !deep_stop_state) else $error("wake did not finish");
  AST_CRYSTAL_OFF: assert property (!crystal_enable [*3] |-> !crystal_run && !pll_ref_clk)
    else $error("crystal ran while disabled");
  AST_RESUS_RING: assert property ($rose(resus_active) |-> ##[0:2] ring_run)
    else $error("recovery without ring");
  AST_FC_START: assert property (fc_start && !fc_busy |=> fc_busy)
    else $error("counter did not start");
  AST_FC_WINDOW: assert property ($fell(fc_busy) |-> busy_len_q == 16'(FC_CYCLES)
    ##[0:1] fc_done) else $error("counter window wrong");
endmodule // chip_clock_source_control_asserts

bind chip_clock_source_control chip_clock_source_control_asserts #(
  .FC_CYCLES(FC_CYCLES)
) u_chip_clock_source_control_asserts (
  .clk, .rst, .ring_run, .crystal_run, .crystal_enable, .pll_ref_clk, .rtc_alarm_in,
  .gpio_wake_in, .gen_clk, .gen_enable, .gen_sleep_gate, .sleep_state, .gpio_route_en,
  .gpio_clk_oe, .deep_stop_req, .deep_stop_state, .resus_active, .fc_start, .fc_busy,
  .fc_done
);

// ==== verif/clk_pin_source.sv ====
`timescale 1ns/1ps
module clk_pin_source #(
  parameter int HALF_NS = 500
) (
  // Control
  input  wire logic run,
  // Pin level
  output logic      pin
);
  initial pin = 1'b0;
  // Off-chip clocks ignore every low-power state; only the bench can stop one.
  always begin
    #(HALF_NS);
    if (run) pin = ~pin;
  end
endmodule // clk_pin_source

// ==== verif/chip_clock_source_control_bench.sv ====
`timescale 1ns/1ps
module chip_clock_source_control_bench;
  import clk_ctrl_pkg::*;
  typedef struct {
    int         g;
    clk_src_t   sel;
    logic [7:0] div;
    int         exp;
  } row_t;
  localparam int W_CYC   = 400;
  localparam int HALF[5] = '{730, 930, 1130, 520, 1310};
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [4:0]           src_run = 5'h1F;
  logic [4:0]           pin;
  logic                 rtc_alarm_in = 1'b0;
  logic                 gpio_wake_in = 1'b0;
  logic                 ring_stop_req = 1'b0;
  logic [DIV_W-1:0]     ring_div = 8'h01;
  logic                 crystal_enable = 1'b0;
  clk_src_t             gen_sel [N_GEN];
  logic [DIV_W-1:0]     gen_div [N_GEN];
  logic [N_GEN-1:0]     gen_enable = 7'h7F;
  logic [N_GEN-1:0]     gen_sleep_gate = 7'h00;
  logic                 sleep_state = 1'b0;
  logic [N_GPOUT-1:0]   gpio_route_en = 4'h0;
  logic                 deep_stop_req = 1'b0;
  logic                 resus_clear = 1'b0;
  clk_src_t             fc_sel = SRC_RING;
  logic                 fc_start = 1'b0;
  logic                 ring_run, crystal_run, pll_ref_clk, deep_stop_state;
  logic                 resus_active, fc_busy, fc_done;
  logic [N_GEN-1:0]     gen_clk;
  logic [N_GPOUT-1:0]   gpio_clk_out, gpio_clk_oe;
  logic [FC_W-1:0]      fc_count;
  int                   n_errors = 0;
  int                   compares = 0;
  int                   i, k;
  row_t                 rows [10];

  always #50 clk = ~clk;

  for (genvar s = 0; s < 5; s++) begin : g_src
    clk_pin_source #(.HALF_NS(HALF[s])) u_clk_pin_source (.run(src_run[s]), .pin(pin[s]));
  end

  chip_clock_source_control #(
    .RESUS_CYCLES(40), .FC_CYCLES(200), .WAKE_CYCLES(2)
  ) u_chip_clock_source_control (
    .clk, .rst, .xin_pin(pin[0]), .gpin0_pin(pin[1]), .gpin1_pin(pin[2]),
    .pll_sys_in(pin[3]), .pll_usb_in(pin[4]), .rtc_alarm_in, .gpio_wake_in, .ring_stop_req,
    .ring_div, .crystal_enable, .ring_run, .crystal_run, .pll_ref_clk, .gen_sel, .gen_div,
    .gen_enable, .gen_sleep_gate, .sleep_state, .gen_clk, .gpio_route_en, .gpio_clk_out,
    .gpio_clk_oe, .deep_stop_req, .deep_stop_state, .resus_clear, .resus_active, .fc_sel,
    .fc_start, .fc_busy, .fc_done, .fc_count
  );

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic check_range(input string what, input int lo, input int hi,
                             input logic [15:0] seen);
    compares++;
    if ((seen >= lo && seen <= hi) !== 1'b1) begin
      n_errors++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", what, lo, hi, seen);
    end
  endtask

  function automatic logic pick(input int g);
    return (g < N_GEN) ? gen_clk[g] : gpio_clk_out[0];
  endfunction

  // Counts rising edges over a fixed window, sampled on the quiet edge.
  task automatic expect_rises(input string what, input int g, input int lo, input int hi);
    int   n;
    logic prev;
    n = 0;
    prev = pick(g);
    repeat (W_CYC) begin
      @(negedge clk);
      if (pick(g) === 1'b1 && prev === 1'b0) n++;
      prev = pick(g);
    end
    check_range(what, lo, hi, 16'(n));
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #3_000_000;
    n_errors++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    foreach (gen_sel[g]) begin
      gen_sel[g] = SRC_RING;
      gen_div[g] = 8'h00;
    end
    rows = '{'{GEN_REF, SRC_RING, 8'h00, 100}, '{GEN_REF, SRC_PLL_USB, 8'h00, 100},
             '{GEN_SYS, SRC_PLL_SYS, 8'h01, 19}, '{GEN_RTC, SRC_XTAL, 8'h00, 27},
             '{GEN_RTC, SRC_PLL_SYS, 8'h00, 27}, '{3, SRC_GPIN0, 8'h00, 21},
             '{4, SRC_GPIN1, 8'h01, 9}, '{5, SRC_PLL_USB, 8'h00, 15},
             '{6, SRC_SYS, 8'h00, 19}, '{3, SRC_RING, 8'h00, 100}};
    cyc(16);
    check_val("reset outputs", 16'h8000, {ring_run, crystal_run, deep_stop_state,
              resus_active, fc_busy, gpio_clk_oe, gen_clk});
    rst = 1'b0;
    crystal_enable = 1'b1;
    gpio_route_en = 4'hF;
    cyc(20);
    check_val("gpio enable", 16'h000F, {12'h000, gpio_clk_oe});
    foreach (rows[r]) begin
      gen_sel[rows[r].g] = rows[r].sel;
      gen_div[rows[r].g] = rows[r].div;
      cyc(60);
      expect_rises($sformatf("row %0d rises", r), rows[r].g, rows[r].exp - 2, rows[r].exp + 2);
    end
    expect_rises("gpio pin rises", 7, 98, 102);
    $display("test table done");
    gen_sel[GEN_REF] = SRC_XTAL;
    cyc(40);
    ring_stop_req = 1'b1;
    cyc(10);
    check_val("ring stopped", 16'h0000, {15'h0000, ring_run});
    expect_rises("stopped ring rises", GEN_GP0, 0, 0);
    ring_stop_req = 1'b0;
    ring_div = 8'h03;
    gen_sel[GEN_REF] = SRC_RING;
    $display("test ring stop done");
    gen_sleep_gate = 7'h78;
    sleep_state = 1'b1;
    cyc(40);
    expect_rises("sleep gated rises", GEN_GP0, 0, 0);
    expect_rises("ring in sleep rises", GEN_REF, 48, 52);
    sleep_state = 1'b0;
    gen_enable = 7'h6F;
    cyc(40);
    expect_rises("disabled rises", 4, 0, 0);
    gen_enable = 7'h7F;
    $display("test sleep done");
    crystal_enable = 1'b0;
    cyc(5);
    check_val("crystal off", 16'h0000, {14'h0000, crystal_run, pll_ref_clk});
    crystal_enable = 1'b1;
    for (k = 0; k < 2; k++) begin
      fc_sel = k ? SRC_RING : SRC_GPIN0;
      fc_start = 1'b1;
      cyc(1);
      fc_start = 1'b0;
      for (i = 0; i < 400 && fc_done !== 1'b1; i++) cyc(1);
      check_range("frequency count", k ? 23 : 9, k ? 27 : 13, fc_count);
    end
    $display("test frequency counter done");
    for (k = 0; k < 2; k++) begin
      deep_stop_req = 1'b1;
      cyc(1);
      deep_stop_req = 1'b0;
      cyc(3);
      check_val("deep stop state", 16'h0004, {13'h0000, deep_stop_state, ring_run, crystal_run});
      expect_rises("external in deep stop", 4, 7, 11);
      expect_rises("ring in deep stop", GEN_GP0, 0, 0);
      if (k) gpio_wake_in = 1'b1; else rtc_alarm_in = 1'b1;
      for (i = 0; i < 100 && deep_stop_state !== 1'b0; i++) cyc(1);
      rtc_alarm_in = 1'b0;
      gpio_wake_in = 1'b0;
      cyc(5);
      check_val("woken state", 16'h0003, {13'h0000, deep_stop_state, ring_run, crystal_run});
      expect_rises("ring after wake", GEN_GP0, 48, 52);
    end
    $display("test deep stop done");
    gen_sel[GEN_REF] = SRC_XTAL;
    ring_stop_req = 1'b1;
    src_run[3] = 1'b0;
    for (i = 0; i < 100 && resus_active !== 1'b1; i++) cyc(1);
    check_val("recovery flag", 16'h0001, {15'h0000, resus_active});
    expect_rises("recovered system rises", GEN_SYS, 23, 27);
    src_run[3] = 1'b1;
    ring_stop_req = 1'b0;
    resus_clear = 1'b1;
    cyc(1);
    resus_clear = 1'b0;
    cyc(3);
    check_val("recovery cleared", 16'h0000, {15'h0000, resus_active});
    $display("test recovery done");
    stop_test();
  end
endmodule // chip_clock_source_control_bench
